/* File: src/fpc_pkg.sv */
// Package for the flash command controller: register map, command codes, timing.
// Assumes a 50 MHz hclk and a parallel NOR flash with 16-bit data bus.
package fpc_pkg;
	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam logic [7:0] REG_SECT = 8'h10;

	// CTRL fields: write starts an operation
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_OP_W = 4;
	localparam int CTRL_BYTE_BIT = 4;
	localparam int CTRL_RST_BIT = 5;

	// STAT fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RDY_BIT = 1;
	localparam int STAT_SECMAP_BIT = 2;
	localparam int STAT_BYPASS_BIT = 3;
	localparam int STAT_WINOPEN_BIT = 4;
	localparam int STAT_ERR_BIT = 5;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_PROG = 4'h1,
		OP_SEC_ENTER = 4'h2,
		OP_SEC_EXIT = 4'h3,
		OP_BYP_ENTER = 4'h4,
		OP_BYP_PROG = 4'h5,
		OP_BYP_EXIT = 4'h6,
		OP_CHIP_ERASE = 4'h7,
		OP_SECT_ERASE = 4'h8,
		OP_SECT_ADD = 4'h9,
		OP_RESET_CMD = 4'ha
	} fpc_op_e;

	// Unlock addresses and command data
	localparam logic [19:0] ADR_UNLOCK1 = 20'h0_0555;
	localparam logic [19:0] ADR_UNLOCK2 = 20'h0_02aa;
	localparam logic [15:0] DAT_UNLOCK1 = 16'h00aa;
	localparam logic [15:0] DAT_UNLOCK2 = 16'h0055;
	localparam logic [15:0] CMD_PROG = 16'h00a0;
	localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
	localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
	localparam logic [15:0] CMD_SECT_ERASE = 16'h0030;
	localparam logic [15:0] CMD_SEC_ENTER = 16'h0088;
	localparam logic [15:0] CMD_BYPASS = 16'h0020;
	localparam logic [15:0] CMD_EXIT_90 = 16'h0090;
	localparam logic [15:0] CMD_EXIT_00 = 16'h0000;
	localparam logic [15:0] CMD_RESET = 16'h00f0;

	// Timing
	localparam int CLK_MHZ = 50;
	localparam int WIN_US = 50;
	localparam int WIN_CYC = WIN_US * CLK_MHZ;
	localparam int WE_LOW_CYC = 3;
	localparam int WE_HIGH_CYC = 3;
	localparam logic [3:0] RST_PULSE_CYC = 4'h5;
endpackage : fpc_pkg

/* File: src/fpc_wr_if.sv */
// Interface between sequencer and write-strobe engine.
// Assumes both ends run on hclk.
`timescale 1ns/100ps
interface fpc_wr_if;
	logic req;
	logic done;
	logic [19:0] addr;
	logic [15:0] data;
	modport seq (output req, output addr, output data, input done);
	modport eng (input req, input addr, input data, output done);
endinterface : fpc_wr_if

/* File: src/fpc_wr_cycle.sv */
// One flash write cycle: drives address/data, pulses chip select and write strobe.
// Assumes the flash samples address on the falling and data on the rising strobe edge.
`timescale 1ns/100ps
module fpc_wr_cycle (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Sequencer side
	fpc_wr_if.eng wr,
	// Flash pins
	output logic [19:0] fl_addr,
	output logic [15:0] fl_dq_o,
	output logic fl_dq_oe,
	output logic fl_ce_n,
	output logic fl_we_n
);
	typedef enum logic [1:0] {W_IDLE, W_LOW, W_HIGH} fpc_w_e;
	fpc_w_e st_ff;
	logic [3:0] cnt_ff;

	assign wr.done = (st_ff == W_HIGH) && (cnt_ff == 4'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= W_IDLE;
			cnt_ff <= 4'h0;
			fl_addr <= 20'h0_0000;
			fl_dq_o <= 16'h0000;
			fl_dq_oe <= 1'b0;
			fl_ce_n <= 1'b1;
			fl_we_n <= 1'b1;
		end else begin
			case (st_ff)
				W_IDLE: begin
					if (wr.req) begin
						// Address and data driven on the same edge as the strobes fall
						fl_addr <= wr.addr;
						fl_dq_o <= wr.data;
						fl_dq_oe <= 1'b1;
						fl_ce_n <= 1'b0;
						fl_we_n <= 1'b0;
						cnt_ff <= 4'(fpc_pkg::WE_LOW_CYC - 1);
						st_ff <= W_LOW;
					end
				end
				W_LOW: begin
					if (cnt_ff == 4'h0) begin
						fl_we_n <= 1'b1;
						fl_ce_n <= 1'b1;
						cnt_ff <= 4'(fpc_pkg::WE_HIGH_CYC - 1);
						st_ff <= W_HIGH;
					end else begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				W_HIGH: begin
					// Data held one more phase for hold time
					if (cnt_ff == 4'h0) begin
						fl_dq_oe <= 1'b0;
						st_ff <= W_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				default: st_ff <= W_IDLE;
			endcase
		end
	end
endmodule : fpc_wr_cycle

/* File: src/fpc_ctrl.sv */
// Flash command controller: AHB-Lite registers, command sequencer, status sampling.
// Assumes one AHB-Lite master, word transfers only, and a flash on the pins below.
//
// What this block does
// - Secure region entered by three writes, left by four writes.
// - Standard program is two unlocks, A0, then address and data.
// - Bypass entry is two unlocks then 20h.
// - Bypass program is A0h then address and data, repeatable.
// - Bypass exit writes 90h then F0h at any address.
// - Chip erase is six writes ending in 10h.
// - Sector erase is six writes, last one sector address with 30h.
// - Queued sector writes are spaced under 50 us apart.
// - Unlocks AA at 555 and 55 at 2AA; set-up codes fixed.
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
module fpc_ctrl #(
	parameter int WIN_CYC = fpc_pkg::WIN_CYC
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Flash pins
	output logic [19:0] fl_addr,
	output logic [15:0] fl_dq_o,
	output logic fl_dq_oe,
	input wire logic [15:0] fl_dq_i,
	output logic fl_ce_n,
	output logic fl_we_n,
	output logic fl_oe_n,
	output logic fl_byte_n,
	output logic fl_reset_n,
	input wire logic ready_busy_n
);
	fpc_wr_if wr();
	fpc_wr_cycle u_wr (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr(wr),
		.fl_addr(fl_addr),
		.fl_dq_o(fl_dq_o),
		.fl_dq_oe(fl_dq_oe),
		.fl_ce_n(fl_ce_n),
		.fl_we_n(fl_we_n)
	);

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] rb_sync_ff;
	logic [15:0] dq_s1_ff, dq_s2_ff;
	// Tracks DQ samples taken with the bus released; our own drive is no status
	logic [1:0] rel_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Ready level, so no false busy right after reset
			rb_sync_ff <= 2'b11;
			dq_s1_ff <= 16'h0000;
			dq_s2_ff <= 16'h0000;
			rel_ff <= 2'b00;
		end else begin
			rb_sync_ff <= {rb_sync_ff[0], ready_busy_n};
			rel_ff <= {rel_ff[0], !fl_dq_oe};
			dq_s1_ff <= fl_dq_i;
			dq_s2_ff <= dq_s1_ff;
		end
	end
	logic dev_ready;
	assign dev_ready = rb_sync_ff[1];
	assign fl_oe_n = fl_dq_oe; // Read enable only when not driving

	////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states
	logic wr_ph_ff;
	logic [7:0] wr_adr_ff;
	logic [7:0] rd_adr;
	logic go_pulse;
	logic [19:0] addr_ff;
	logic [15:0] data_ff;
	logic [19:0] sect_ff;
	logic [3:0] op_ff;
	logic byte_ff;
	logic err_ff;
	logic busy;
	logic secmap_ff, bypass_ff, win_ff;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign go_pulse = wr_ph_ff && (wr_adr_ff == fpc_pkg::REG_CTRL);
	assign rd_adr = haddr[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_ff <= 1'b0;
			wr_adr_ff <= 8'h00;
		end else if (hready) begin
			wr_ph_ff <= hsel && htrans[1] && hwrite;
			wr_adr_ff <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_ff <= 20'h0_0000;
			data_ff <= 16'h0000;
			sect_ff <= 20'h0_0000;
			op_ff <= 4'h0;
			byte_ff <= 1'b0;
		end else if (wr_ph_ff) begin
			case (wr_adr_ff)
				fpc_pkg::REG_ADDR: addr_ff <= hwdata[19:0];
				fpc_pkg::REG_DATA: data_ff <= hwdata[15:0];
				fpc_pkg::REG_SECT: sect_ff <= hwdata[19:0];
				fpc_pkg::REG_CTRL: begin
					op_ff <= hwdata[fpc_pkg::CTRL_OP_LSB +: fpc_pkg::CTRL_OP_W];
					byte_ff <= hwdata[fpc_pkg::CTRL_BYTE_BIT];
				end
				default: ;
			endcase
		end
	end
	assign fl_byte_n = !byte_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hsel && htrans[1] && !hwrite && hready) begin
			case (rd_adr)
				fpc_pkg::REG_ADDR: hrdata <= {12'h000, addr_ff};
				fpc_pkg::REG_DATA: hrdata <= {16'h0000, dq_s2_ff};
				fpc_pkg::REG_SECT: hrdata <= {12'h000, sect_ff};
				fpc_pkg::REG_CTRL: hrdata <= {26'h000_0000, 1'b0, byte_ff, op_ff};
				fpc_pkg::REG_STAT: hrdata <= {26'h000_0000, err_ff, win_ff, bypass_ff,
					secmap_ff, dev_ready, busy};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Command sequencer
	typedef enum logic [2:0] {S_IDLE, S_SEND, S_WAITW, S_RBWAIT, S_RESET} fpc_s_e;
	fpc_s_e st_ff;
	logic [2:0] idx_ff, len_ff;
	logic [3:0] cur_op_ff;
	logic [3:0] rst_cnt_ff;
	logic [19:0] seq_a;
	logic [15:0] seq_d;
	logic [15:0] win_cnt_ff;

	assign busy = (st_ff != S_IDLE);

	// Address/data of write number idx for the current operation
	always_comb begin
		seq_a = (idx_ff[0]) ? fpc_pkg::ADR_UNLOCK2 : fpc_pkg::ADR_UNLOCK1;
		seq_d = (idx_ff[0]) ? fpc_pkg::DAT_UNLOCK2 : fpc_pkg::DAT_UNLOCK1;
		case (fpc_pkg::fpc_op_e'(cur_op_ff))
			fpc_pkg::OP_PROG: if (idx_ff == 3'd2) seq_d = fpc_pkg::CMD_PROG;
				else if (idx_ff == 3'd3) begin
				seq_a = addr_ff;
				seq_d = data_ff;
			end
			fpc_pkg::OP_SEC_ENTER: if (idx_ff == 3'd2) seq_d = fpc_pkg::CMD_SEC_ENTER;
			fpc_pkg::OP_SEC_EXIT: if (idx_ff == 3'd2) seq_d = fpc_pkg::CMD_EXIT_90;
				else if (idx_ff == 3'd3) seq_d = fpc_pkg::CMD_EXIT_00;
			fpc_pkg::OP_BYP_ENTER: if (idx_ff == 3'd2) seq_d = fpc_pkg::CMD_BYPASS;
			fpc_pkg::OP_BYP_PROG: begin
				seq_a = addr_ff;
				seq_d = (idx_ff == 3'd0) ? fpc_pkg::CMD_PROG : data_ff;
			end
			fpc_pkg::OP_BYP_EXIT: begin
				seq_a = addr_ff;
				seq_d = (idx_ff == 3'd0) ? fpc_pkg::CMD_EXIT_90 : fpc_pkg::CMD_RESET;
			end
			fpc_pkg::OP_CHIP_ERASE, fpc_pkg::OP_SECT_ERASE: begin
				if (idx_ff == 3'd2) seq_d = fpc_pkg::CMD_ERASE_SETUP;
				if (idx_ff == 3'd3) begin
					seq_a = fpc_pkg::ADR_UNLOCK1;
					seq_d = fpc_pkg::DAT_UNLOCK1;
				end
				if (idx_ff == 3'd4) begin
					seq_a = fpc_pkg::ADR_UNLOCK2;
					seq_d = fpc_pkg::DAT_UNLOCK2;
				end
				if (idx_ff == 3'd5) begin
					seq_a = (cur_op_ff == fpc_pkg::OP_CHIP_ERASE) ? fpc_pkg::ADR_UNLOCK1 : sect_ff;
					seq_d = (cur_op_ff == fpc_pkg::OP_CHIP_ERASE) ? fpc_pkg::CMD_CHIP_ERASE
						: fpc_pkg::CMD_SECT_ERASE;
				end
			end
			fpc_pkg::OP_SECT_ADD: begin
				seq_a = sect_ff;
				seq_d = fpc_pkg::CMD_SECT_ERASE;
			end
			default: begin
				seq_a = addr_ff;
				seq_d = fpc_pkg::CMD_RESET;
			end
		endcase
	end

	assign wr.req = (st_ff == S_SEND);
	assign wr.addr = seq_a;
	assign wr.data = seq_d;

	// Legality of a new order against the mode the flash is in
	function automatic logic op_legal(input logic [3:0] op, input logic byp,
		input logic sec, input logic win);
		case (fpc_pkg::fpc_op_e'(op))
			fpc_pkg::OP_BYP_PROG, fpc_pkg::OP_BYP_EXIT: op_legal = byp;
			fpc_pkg::OP_BYP_ENTER: op_legal = !byp && !sec;
			fpc_pkg::OP_SECT_ADD: op_legal = win && !byp;
			fpc_pkg::OP_NONE: op_legal = 1'b0;
			default: op_legal = !byp && (op <= fpc_pkg::OP_RESET_CMD);
		endcase
	endfunction

	// Code as it arrives; op_ff only lands on the same edge as the start
	logic [3:0] new_op;
	assign new_op = hwdata[fpc_pkg::CTRL_OP_LSB +: fpc_pkg::CTRL_OP_W];
	logic [2:0] op_len;
	always_comb begin
		case (fpc_pkg::fpc_op_e'(new_op))
			fpc_pkg::OP_PROG, fpc_pkg::OP_SEC_EXIT: op_len = 3'd4;
			fpc_pkg::OP_SEC_ENTER, fpc_pkg::OP_BYP_ENTER: op_len = 3'd3;
			fpc_pkg::OP_BYP_PROG, fpc_pkg::OP_BYP_EXIT: op_len = 3'd2;
			fpc_pkg::OP_CHIP_ERASE, fpc_pkg::OP_SECT_ERASE: op_len = 3'd6;
			default: op_len = 3'd1;
		endcase
	end

	logic hw_rst_req;
	assign hw_rst_req = wr_ph_ff && (wr_adr_ff == fpc_pkg::REG_CTRL)
		&& hwdata[fpc_pkg::CTRL_RST_BIT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= S_IDLE;
			idx_ff <= 3'd0;
			len_ff <= 3'd0;
			cur_op_ff <= 4'h0;
			rst_cnt_ff <= 4'h0;
			err_ff <= 1'b0;
		end else if (hw_rst_req) begin
			st_ff <= S_RESET;
			rst_cnt_ff <= fpc_pkg::RST_PULSE_CYC;
		end else begin
			case (st_ff)
				S_IDLE: begin
					if (go_pulse) begin
						if (op_legal(new_op, bypass_ff, secmap_ff, win_ff)) begin
							cur_op_ff <= new_op;
							len_ff <= op_len;
							idx_ff <= 3'd0;
							err_ff <= 1'b0;
							st_ff <= S_SEND;
						end else begin
							err_ff <= 1'b1;
						end
					end
				end
				S_SEND: st_ff <= S_WAITW;
				S_WAITW: begin
					if (wr.done) begin
						if (idx_ff == len_ff - 3'd1) begin
							// Programs and chip erase hold off until ready returns
							st_ff <= (cur_op_ff == fpc_pkg::OP_PROG
								|| cur_op_ff == fpc_pkg::OP_BYP_PROG
								|| cur_op_ff == fpc_pkg::OP_CHIP_ERASE) ? S_RBWAIT : S_IDLE;
						end else begin
							idx_ff <= idx_ff + 3'd1;
							st_ff <= S_SEND;
						end
					end
				end
				// Flag may lag the strobe; leave once ready is seen with the bus released, busy need not be seen first
				S_RBWAIT: if (dev_ready && !fl_dq_oe) st_ff <= S_IDLE;
				S_RESET: begin
					if (rst_cnt_ff == 4'h0) st_ff <= S_IDLE;
					else rst_cnt_ff <= rst_cnt_ff - 4'h1;
				end
				default: st_ff <= S_IDLE;
			endcase
		end
	end
	assign fl_reset_n = (st_ff != S_RESET);

	////////////////////////////////////////////////////////////////
	// Mode tracking and sector-erase window
	logic last_done;
	assign last_done = (st_ff == S_WAITW) && wr.done && (idx_ff == len_ff - 3'd1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			secmap_ff <= 1'b0;
			bypass_ff <= 1'b0;
		end else if (st_ff == S_RESET) begin
			secmap_ff <= 1'b0;
			bypass_ff <= 1'b0;
		end else if (last_done) begin
			case (fpc_pkg::fpc_op_e'(cur_op_ff))
				fpc_pkg::OP_SEC_ENTER: secmap_ff <= 1'b1;
				fpc_pkg::OP_SEC_EXIT: secmap_ff <= 1'b0;
				fpc_pkg::OP_BYP_ENTER: bypass_ff <= 1'b1;
				fpc_pkg::OP_BYP_EXIT: bypass_ff <= 1'b0;
				default: ;
			endcase
		end
	end

	// Host-side copy of the window; other commands in it abort the erase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			win_ff <= 1'b0;
			win_cnt_ff <= 16'h0000;
		end else if (st_ff == S_RESET) begin
			win_ff <= 1'b0;
		end else if (last_done && (cur_op_ff == fpc_pkg::OP_SECT_ERASE
			|| cur_op_ff == fpc_pkg::OP_SECT_ADD)) begin
			win_ff <= 1'b1;
			// Flash window runs from the strobe rise; a queued write needs a strobe too
			win_cnt_ff <= 16'(WIN_CYC - fpc_pkg::WE_LOW_CYC - fpc_pkg::WE_HIGH_CYC - 3);
		end else if (st_ff == S_SEND && cur_op_ff != fpc_pkg::OP_SECT_ADD) begin
			win_ff <= 1'b0;
		end else if (win_ff && st_ff == S_IDLE) begin
			// Closes early by a margin so queued writes land inside the window
			if (win_cnt_ff == 16'h0000 || (dq_s2_ff[3] && rel_ff[1])) win_ff <= 1'b0;
			else win_cnt_ff <= win_cnt_ff - 16'h0001;
		end
	end
endmodule : fpc_ctrl

/* File: test/fpc_ctrl_chk.sv */
// Checker for the flash pin timing driven by fpc_ctrl.
// Assumes a bind onto fpc_ctrl and one hclk domain.
`timescale 1ns/100ps
module fpc_ctrl_chk #(
	parameter int WIN_CYC = fpc_pkg::WIN_CYC
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Flash pins
	input wire logic [19:0] fl_addr,
	input wire logic [15:0] fl_dq_o,
	input wire logic fl_dq_oe,
	input wire logic fl_ce_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n,
	input wire logic fl_reset_n
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_we_low;
		!fl_we_n [*3] ##1 fl_we_n;
	endsequence
	sequence s_data_held;
		($stable(fl_dq_o) && fl_dq_oe) [*3];
	endsequence
	property p_pair; fl_we_n == fl_ce_n; endproperty
	a_pair: assert property (p_pair) else $error("strobes apart");
	property p_we_len; $fell(fl_we_n) |-> s_we_low; endproperty
	a_we_len: assert property (p_we_len) else $error("strobe width");
	property p_hold; $rose(fl_we_n) |-> s_data_held; endproperty
	a_hold: assert property (p_hold) else $error("data not held");
	property p_addr; !fl_we_n && !$past(fl_we_n) |-> $stable(fl_addr); endproperty
	a_addr: assert property (p_addr) else $error("address moved");
	property p_gap; $rose(fl_we_n) |-> fl_we_n [*4]; endproperty
	a_gap: assert property (p_gap) else $error("writes too close");
	property p_dir; !fl_we_n |-> fl_dq_oe && fl_oe_n; endproperty
	a_dir: assert property (p_dir) else $error("bus not driven");
	property p_rst_quiet; !fl_reset_n |-> fl_we_n && fl_ce_n && !fl_dq_oe; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("write in reset");
	property p_rst_len; $fell(fl_reset_n) |-> !fl_reset_n [*4]; endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
	c_rst: cover property ($fell(fl_reset_n));
endmodule : fpc_ctrl_chk

bind fpc_ctrl fpc_ctrl_chk #(.WIN_CYC(WIN_CYC)) i_chk (.hclk(hclk), .hresetn(hresetn),
	.fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
	.fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n));

/* File: test/fpc_flash_model.sv */
// Behavioural flash: decodes command writes, logs them, drives status.
// Assumes chip select and write strobe frame each write cycle.
`timescale 1ns/100ps
module fpc_flash_model #(
	parameter int WIN_NS = 1000,
	parameter int ERASE_NS = 3000
) (
	// Flash pins
	input wire logic [19:0] fl_addr,
	input wire logic [15:0] fl_dq_o,
	input wire logic fl_dq_oe,
	input wire logic fl_ce_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n,
	input wire logic fl_byte_n,
	input wire logic fl_reset_n,
	// Status back to the controller
	output logic [15:0] fl_dq_i,
	output logic ready_busy_n
);
	logic [19:0] la[$];
	logic [15:0] ld[$];
	logic lb[$];
	logic [19:0] lat_a;
	logic [15:0] h1, h2, h3, pd;
	logic wr_open, sec, byp, win, erase, tog;
	realtime busy_until, win_until;
	initial begin
		{wr_open, sec, byp, win, erase, tog} = '0;
		{h1, h2, h3, pd} = '0;
		busy_until = 0;
		win_until = 0;
		fl_dq_i = 16'h5a5a;
		ready_busy_n = 1'b1;
	end
	task automatic start(input realtime ns, input logic er);
		busy_until = $realtime + ns;
		erase = er;
		ready_busy_n = 1'b0;
	endtask : start
	task automatic take(input logic [19:0] a, input logic [15:0] d);
		logic hit;
		hit = 1'b1;
		if ($realtime < busy_until) return;
		la.push_back(a);
		ld.push_back(d);
		lb.push_back(fl_byte_n);
		if (byp) begin
			if (h1 == 16'h00a0) start(200 + 400 * d[3:0], 1'b0);
			else if (h1 == 16'h0090 && d == 16'h00f0) byp = 1'b0;
			else hit = 1'b0;
		end else if (win) begin
			if (d == 16'h0030) win_until = $realtime + WIN_NS;
			else win = 1'b0;
		end else if (h1 == 16'h00a0 && h2 == 16'h0055) start(200 + 400 * d[3:0], 1'b0);
		else if (h1 == 16'h0055 && h2 == 16'h00aa && h3 == 16'h0080) begin
			if (d == 16'h0010) start(ERASE_NS, 1'b1);
			win = d == 16'h0030;
			win_until = $realtime + WIN_NS;
		end else if (h1 == 16'h0055 && h2 == 16'h00aa && d == 16'h0088) sec = 1'b1;
		else if (h1 == 16'h0055 && h2 == 16'h00aa && d == 16'h0020) byp = !sec;
		else if (h1 == 16'h0090 && h2 == 16'h0055 && d == 16'h0000) sec = 1'b0;
		else hit = 1'b0;
		if (hit) {h1, h2, h3} = '0;
		else {h3, h2, h1} = {h2, h1, d};
		pd = d;
	endtask : take
	always @(negedge fl_we_n or negedge fl_ce_n) begin
		if (!fl_we_n && !fl_ce_n) begin
			lat_a = fl_addr;
			wr_open = 1'b1;
		end
	end
	always @(posedge fl_we_n or posedge fl_ce_n) begin
		if (wr_open) begin
			wr_open = 1'b0;
			take(lat_a, fl_dq_oe ? fl_dq_o : 16'hxxxx);
		end
	end
	// Free running status loop, unrelated to hclk on purpose
	always #7 begin
		if (!fl_reset_n) begin
			busy_until = 0;
			{win, byp, sec, h1, h2} = '0;
		end
		if (win && $realtime >= win_until) begin
			win = 1'b0;
			start(ERASE_NS, 1'b1);
		end
		tog = ~tog;
		ready_busy_n = $realtime >= busy_until;
		if (fl_oe_n) fl_dq_i = ~fl_dq_i;
		else if (!ready_busy_n) fl_dq_i = {8'h00, ~pd[7], tog, 2'b00, erase, erase & tog, 2'b00};
		else fl_dq_i = pd;
	end
endmodule : fpc_flash_model

/* File: test/test_flash_program_erase_command_fsm.sv */
// Testbench: AHB-Lite stimulus for fpc_ctrl against the flash model.
// Assumes the package, design, checker and model are compiled before it.
`timescale 1ns/100ps
module test_flash_program_erase_command_fsm;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_byte_n, fl_reset_n, ready_busy_n;
	logic [19:0] fl_addr;
	logic [15:0] fl_dq_o, fl_dq_i;
	int fails, n_compared, cyc, seed;
	int ea[$], ed[$];
	bit sec, byp, win, refused, eb;
	wire hready = hreadyout;
	fpc_ctrl #(.WIN_CYC(50)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .fl_addr, .fl_dq_o,
		.fl_dq_oe, .fl_dq_i, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_byte_n, .fl_reset_n,
		.ready_busy_n);
	fpc_flash_model #(.WIN_NS(1000), .ERASE_NS(3000)) i_flash (.fl_addr, .fl_dq_o,
		.fl_dq_oe, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_byte_n, .fl_reset_n, .fl_dq_i,
		.ready_busy_n);
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails++;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s: got %h expected %h", $time, m, got, exp);
		end
	endtask : chk
	// Master holds each phase until hready is sampled high
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		{hsel, htrans, hwrite} <= {1'b1, 2'b10, w};
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hready !== 1'b1);
		{hsel, htrans} <= 3'b000;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic wait_stat(input int b, input logic v);
		for (int i = 0; i < 900; i++) begin
			ahb(0, fpc_pkg::REG_STAT, 32'h0);
			if (rd[b] === v) break;
		end
	endtask : wait_stat
	task automatic push(input int a, input int d);
		ea.push_back(a);
		ed.push_back(d);
	endtask : push
	// Reference sequencer: expected flash writes and mode bits per op
	task automatic model(input int op, input int a, input int d, input int s);
		refused = (byp && op != 5 && op != 6) || (op == 4 && sec) || (op == 9 && !win);
		if (refused) return;
		for (int k = 0; k < 2 && op inside {1, 2, 3, 4, 7, 8}; k++) begin
			push(12'h555, 8'haa);
			push(12'h2aa, 8'h55);
			if (k == 0) push(12'h555, op == 1 ? 8'ha0 : op == 2 ? 8'h88 : op == 3 ? 8'h90 :
				op == 4 ? 8'h20 : 8'h80);
			if (op < 7) break;
		end
		if (op == 5) push(-1, 8'ha0);
		if (op == 6) push(-1, 8'h90);
		if (op == 1 || op == 5) push(a, d);
		if (op == 3) push(-1, 8'h00);
		if (op == 6 || op == 10) push(-1, 8'hf0);
		if (op == 7) push(12'h555, 8'h10);
		if (op == 8 || op == 9) push(s, 8'h30);
		sec = op == 2 ? 1'b1 : op == 3 ? 1'b0 : sec;
		byp = op == 4 ? 1'b1 : op == 6 ? 1'b0 : byp;
		win = op == 8 || op == 9;
	endtask : model
	task automatic do_op(input int op, input int a, input int d, input int s, input bit bm);
		eb = bm;
		model(op, a, d, s);
		ahb(1, fpc_pkg::REG_ADDR, a);
		ahb(1, fpc_pkg::REG_DATA, d);
		ahb(1, fpc_pkg::REG_SECT, s);
		ahb(1, fpc_pkg::REG_CTRL, {26'h0, 1'b0, bm, op[3:0]});
	endtask : do_op
	task automatic finish_op(input string m);
		repeat (3) @(posedge hclk);
		wait_stat(0, 1'b0);
		chk(rd[5:2], {refused, win, byp, sec}, m);
		chk(i_flash.la.size(), ea.size(), m);
		while (ea.size() > 0 && i_flash.la.size() > 0) begin
			if (ea[0] >= 0) chk(i_flash.la[0], ea[0], m);
			chk(i_flash.ld.pop_front(), ed.pop_front(), m);
			chk(i_flash.lb.pop_front(), !eb, m);
			void'(ea.pop_front());
			void'(i_flash.la.pop_front());
		end
		ea.delete();
		ed.delete();
		i_flash.la.delete();
		i_flash.ld.delete();
		i_flash.lb.delete();
	endtask : finish_op
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, cyc} = '0;
		hsize = 3'b010;
		seed = 32'h2ec0_6d86;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(0, fpc_pkg::REG_STAT, 32'h0);
		chk(rd, 32'h0000_0002, "status after reset");
		ahb(1, 8'h20, 32'hffff_ffff);
		ahb(0, 8'h20, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		for (int i = 0; i < 4; i++) begin
			do_op(1, $random(seed) & 20'hf_ffff, $random(seed) & 16'hffff, 0, i[0]);
			finish_op("program");
		end
		do_op(1, 20'h0_4321, 16'h3c4f, 0, 0);
		repeat (30) @(posedge hclk);
		ahb(0, fpc_pkg::REG_STAT, 32'h0);
		chk(rd[1:0], 2'b01, "busy while programming");
		ahb(0, fpc_pkg::REG_DATA, 32'h0);
		chk(rd[7], 1'b1, "polling bit");
		finish_op("slow program");
		do_op(2, 0, 0, 0, 0);
		finish_op("secure enter");
		do_op(4, 0, 0, 0, 0);
		finish_op("bypass in secure");
		do_op(3, 0, 0, 0, 0);
		finish_op("secure exit");
		do_op(4, 0, 0, 0, 0);
		finish_op("bypass enter");
		for (int i = 0; i < 2; i++) begin
			do_op(5, $random(seed) & 20'hf_ffff, $random(seed) & 16'hffff, 0, 1);
			finish_op("bypass program");
		end
		do_op(1, 20'h0_0100, 16'h1234, 0, 0);
		finish_op("program in bypass");
		do_op(6, 0, 0, 0, 0);
		finish_op("bypass exit");
		do_op(7, 0, 0, 0, 0);
		repeat (60) @(posedge hclk);
		ahb(1, fpc_pkg::REG_CTRL, 32'h0000_0001);
		finish_op("chip erase");
		do_op(8, 0, 0, 20'h1_0000, 0);
		finish_op("sector erase");
		do_op(9, 0, 0, 20'h3_0000, 0);
		finish_op("queued sector");
		wait_stat(4, 1'b0);
		win = 1'b0;
		repeat (10) @(posedge hclk);
		ahb(0, fpc_pkg::REG_STAT, 32'h0);
		chk(rd[1], 1'b0, "erase running");
		wait_stat(1, 1'b1);
		do_op(8, 0, 0, 20'h2_0000, 0);
		finish_op("sector erase again");
		do_op(10, 0, 0, 0, 0);
		finish_op("cancel in window");
		repeat (100) @(posedge hclk);
		ahb(0, fpc_pkg::REG_STAT, 32'h0);
		chk(rd[1], 1'b1, "no erase after cancel");
		do_op(1, 20'h0_1234, 16'h0f0f, 0, 0);
		repeat (30) @(posedge hclk);
		ahb(1, fpc_pkg::REG_CTRL, 32'h0000_0020);
		finish_op("hardware reset abort");
		repeat (20) @(posedge hclk);
		ahb(0, fpc_pkg::REG_STAT, 32'h0);
		chk(rd[1:0], 2'b10, "ready after abort");
		stop_test();
	end
endmodule : test_flash_program_erase_command_fsm
